/* File: dv/dsp_shift_saturate_datapath_tb.sv */
/*
 * self-checking bench for the arithmetic datapath: multiplier, divider,
 * barrel shifter and write saturation, random stimulus with fixed seed.
 * assumes the datapath registers each result one cycle after its valid input.
 */
`timescale 1ns/1ps
module dsp_shift_saturate_datapath_tb;
	logic ref_clk_in = 1'b0, nrst_in = 1'b0;
	logic mul_valid_in = 1'b0, mul_a_signed_in = 1'b0, mul_b_signed_in = 1'b0;
	logic [15:0] mul_a_in = '0, mul_b_in = '0, div_divisor_in = '0, xbus_in = '0;
	logic div_start_in = 1'b0, div_step_in = 1'b0, div_wide_in = 1'b0;
	logic div_signed_in = 1'b0, div_frac_in = 1'b0;
	logic [31:0] div_dividend_in = '0;
	logic shift_valid_in = 1'b0, shift_arith_in = 1'b0, shift_dsp_in = 1'b0;
	logic [1:0] shift_src_in = '0;
	logic signed [5:0] shift_amt_in = '0;
	logic [39:0] acc_a_in = '0, acc_b_in = '0, shift_acc_out, es_acc = '0;
	logic data_write_saturate_enable_in = 1'b0, wr_valid_in = 1'b0;
	logic wr_acc_ovf_in = 1'b0, wr_round_ovf_in = 1'b0, wr_acc_sign_in = 1'b0;
	logic [15:0] wr_round_in = '0, wr_data_out, div_quotient_out, div_remainder_out;
	logic [15:0] shift_word_out, es_word = '0, ew = '0;
	logic [33:0] mul_prod_out, em = '0;
	logic mul_valid_out, div_busy_out, div_done_out, shift_valid_out, wr_valid_out;
	logic pm = 1'b0, ps = 1'b0, pw = 1'b0;
	int miscompares = 0, total_checks = 0, cycles = 0;

	dsp_shift_saturate_datapath i_dut (.ref_clk_in, .nrst_in, .mul_valid_in, .mul_a_in,
		.mul_b_in, .mul_a_signed_in, .mul_b_signed_in, .mul_prod_out, .mul_valid_out,
		.div_start_in, .div_step_in, .div_wide_in, .div_signed_in, .div_frac_in,
		.div_dividend_in, .div_divisor_in, .div_busy_out, .div_done_out, .div_quotient_out,
		.div_remainder_out, .shift_valid_in, .shift_src_in, .shift_arith_in, .shift_dsp_in,
		.shift_amt_in, .acc_a_in, .acc_b_in, .xbus_in, .shift_acc_out, .shift_word_out,
		.shift_valid_out, .data_write_saturate_enable_in, .wr_valid_in, .wr_round_in,
		.wr_acc_ovf_in, .wr_round_ovf_in, .wr_acc_sign_in, .wr_data_out, .wr_valid_out);

	always #2.5 ref_clk_in = ~ref_clk_in;

	task automatic summarize();
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	// the whole run is a few hundred cycles; this only catches a hang
	always @(posedge ref_clk_in) begin
		cycles++;
		if (cycles == 5000) begin
			miscompares++;
			$display("BAD %0t run did not finish", $time);
			summarize();
		end
	end

	task automatic check(input logic [39:0] seen, input logic [39:0] exp, input string what);
		total_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("BAD %0t %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask

	function automatic logic [33:0] f_mul(input logic [15:0] a, b, input logic sa, sb);
		logic signed [33:0] x, y;
		x = {{18{sa & a[15]}}, a};
		y = {{18{sb & b[15]}}, b};
		return x * y;
	endfunction

	function automatic logic [39:0] f_shift(input logic [1:0] src, input logic ar, input int n,
		input logic [39:0] a, b, input logic [15:0] xb);
		logic [39:0] op;
		int m;
		m = (n > 16) ? 16 : (n < -16) ? -16 : n;
		op = (src == 2'h0) ? a : (src == 2'h1) ? b :
			(m >= 0) ? {{8{ar & xb[15]}}, xb, 16'h0000} : {24'h0, xb};
		if (m >= 0) return ar ? 40'($signed(op) >>> m) : op >> m;
		return op << (-m);
	endfunction

	function automatic logic [15:0] f_sat(input logic en, ao, ro, sg, input logic [15:0] w);
		if (en && (ao || ro)) return sg ? dsp_datapath_pkg::SAT_NEG : dsp_datapath_pkg::SAT_POS;
		return w;
	endfunction

	// results hold between valid inputs, so every cycle compares against the last expectation
	task automatic check_prev();
		check(40'(mul_valid_out), 40'(pm), "mul valid");
		check(40'(mul_prod_out), 40'(em), "product");
		check(40'(shift_valid_out), 40'(ps), "shift valid");
		check(shift_acc_out, es_acc, "shift acc");
		check(40'(shift_word_out), 40'(es_word), "shift word");
		check(40'(wr_valid_out), 40'(pw), "write valid");
		check(40'(wr_data_out), 40'(ew), "write data");
	endtask

	task automatic div_run(input logic w, s, f, input logic [31:0] dd, input logic [15:0] dv,
		input int gap, input logic num, input logic [15:0] q, r);
		div_wide_in = w;
		div_signed_in = s;
		div_frac_in = f;
		div_dividend_in = dd;
		div_divisor_in = dv;
		div_start_in = 1'b1;
		@(negedge ref_clk_in);
		div_start_in = 1'b0;
		for (int k = 0; k < 18; k++) begin
			check(40'(div_busy_out), 40'h1, "busy in run");
			check(40'(div_done_out), 40'h0, "early done");
			div_step_in = 1'b1;
			@(negedge ref_clk_in);
			if (k == 8 && gap > 0) begin
				// an interrupt between steps: state must survive the stall
				div_step_in = 1'b0;
				repeat (gap) @(negedge ref_clk_in);
			end
		end
		div_step_in = 1'b0;
		check(40'(div_done_out), 40'h1, "done after 19 cycles");
		check(40'(div_busy_out), 40'h0, "busy after end");
		@(negedge ref_clk_in);
		if (num) check(40'(div_quotient_out), 40'(q), "quotient");
		if (num) check(40'(div_remainder_out), 40'(r), "remainder");
		div_step_in = 1'b1;
		@(negedge ref_clk_in);
		div_step_in = 1'b0;
		check(40'(div_done_out), 40'h1, "stray step");
		$display("divide test done");
	endtask

	initial begin
		int n;
		int tn[9] = '{-16, 20, 0, 0, 16, 1, -20, -1, -3};
		logic [39:0] er;
		void'($urandom(8));
		repeat (16) @(negedge ref_clk_in);
		check_prev();
		check(40'(div_busy_out), 40'h0, "busy in reset");
		check(40'({div_done_out, div_quotient_out, div_remainder_out}), 40'h0, "div reset");
		nrst_in = 1'b1;
		for (int i = 0; i < 300; i++) begin
			@(negedge ref_clk_in);
			check_prev();
			mul_valid_in = 1'($urandom);
			{mul_a_in, mul_b_in} = $urandom;
			{mul_a_signed_in, mul_b_signed_in} = (i < 4) ? 2'(i) : 2'($urandom);
			if (i == 3) {mul_a_in, mul_b_in} = 32'h8000_8000;
			pm = mul_valid_in;
			if (pm) em = f_mul(mul_a_in, mul_b_in, mul_a_signed_in, mul_b_signed_in);
			n = (i < 9) ? tn[i] : int'($urandom_range(40, 0)) - 20;
			shift_amt_in = 6'(n);
			shift_src_in = (i < 9) ? 2'(i % 3) : 2'($urandom_range(2, 0));
			shift_valid_in = (i < 9) ? 1'b1 : 1'($urandom);
			shift_arith_in = (i < 9) ? (i == 4 || i == 5) : 1'($urandom);
			shift_dsp_in = (i < 9) ? (i != 2 && i != 5) : 1'($urandom);
			acc_a_in = {8'($urandom), 32'($urandom)};
			acc_b_in = {8'($urandom), 32'($urandom)};
			xbus_in = 16'($urandom);
			ps = shift_valid_in;
			er = f_shift(shift_src_in, shift_arith_in, n, acc_a_in, acc_b_in, xbus_in);
			if (ps && shift_dsp_in)
				es_acc = er;
			// integer results: x bus right shifts read back from the upper placement
			if (ps && !shift_dsp_in)
				es_word = (shift_src_in == 2'h2 && n >= 0) ? er[31:16] : er[15:0];
			wr_valid_in = (i < 8) ? 1'b1 : 1'($urandom);
			{data_write_saturate_enable_in, wr_acc_ovf_in, wr_round_ovf_in, wr_acc_sign_in} =
				(i < 8) ? {1'b1, 3'(i)} : 4'($urandom);
			wr_round_in = 16'($urandom);
			pw = wr_valid_in;
			if (pw) ew = f_sat(data_write_saturate_enable_in, wr_acc_ovf_in, wr_round_ovf_in,
				wr_acc_sign_in, wr_round_in);
		end
		@(negedge ref_clk_in);
		check_prev();
		{mul_valid_in, shift_valid_in, wr_valid_in} = 3'h0;
		{pm, ps, pw} = 3'h0;
		@(negedge ref_clk_in);
		check_prev();
		$display("stream test done");
		div_run(1'b0, 1'b0, 1'b0, 32'h0000_03e8, 16'h0007, 0, 1'b1, 16'h008e, 16'h0006);
		div_run(1'b1, 1'b0, 1'b0, 32'h0001_0000, 16'h0010, 5, 1'b1, 16'h1000, 16'h0000);
		div_run(1'b0, 1'b1, 1'b1, $urandom, 16'h4000, 3, 1'b0, 16'h0000, 16'h0000);
		div_run(1'b1, 1'b1, 1'b0, $urandom, 16'h7001, 1, 1'b0, 16'h0000, 16'h0000);
		summarize();
	end
endmodule

/* File: hw/div_step_engine.sv */
/*
 * iterative non-restoring-free shift/subtract divider, one quotient bit per step for the first sixteen of eighteen steps.
 * assumes the controller issues start once, then a step each repeated divide cycle.
 */
`timescale 1ns/1ps
module div_step_engine (
	input wire logic ref_clk_in,
	input wire logic nrst_in,
	div_step_if.engine d
);
	localparam int N_STEPS = dsp_datapath_pkg::DIV_STEPS;
	dsp_datapath_pkg::div_state_t state_r;
	logic [4:0] cnt_r;
	logic [32:0] rem_r;
	logic [31:0] quo_r;
	logic [15:0] dvs_r;
	logic neg_q_r;
	logic neg_r_r;
	logic [31:0] abs_dvd;
	logic [15:0] abs_dvs;
	logic [32:0] trial;
	logic dvd_neg;

	initial begin
		if (N_STEPS < 17 || N_STEPS > 31)
			$error("divide step count out of range");
	end

	always_comb begin
		// the dividend sign sits at bit 15 for the narrow forms and bit 31 for the wide one
		dvd_neg = d.signed_op & (d.wide ? d.dividend[31] : d.dividend[15]);
		abs_dvd = d.wide ? d.dividend : {{16{d.dividend[15] & d.signed_op}}, d.dividend[15:0]};
		if (d.frac)
			abs_dvd = d.wide ? d.dividend : {d.dividend[15:0], 16'h0000};
		if (dvd_neg)
			abs_dvd = 32'h0 - abs_dvd;
		abs_dvs = (d.signed_op && d.divisor[15]) ? 16'h0 - d.divisor : d.divisor;
		trial = {rem_r[31:0], quo_r[31]} - {17'h0, dvs_r};
	end

	// state lives only here and moves only on a start or a step, so stalls between steps are harmless
	always_ff @(posedge ref_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			state_r <= dsp_datapath_pkg::DIV_IDLE;
			cnt_r <= 5'h00;
			rem_r <= 33'h0;
			quo_r <= 32'h0;
			dvs_r <= 16'h0000;
			neg_q_r <= 1'b0;
			neg_r_r <= 1'b0;
		end else if (d.start) begin
			state_r <= dsp_datapath_pkg::DIV_RUN;
			cnt_r <= 5'h00;
			// upper dividend half seeds the remainder, lower half is shifted in bit by bit
			rem_r <= {17'h00000, abs_dvd[31:16]};
			quo_r <= {abs_dvd[15:0], 16'h0000};
			dvs_r <= abs_dvs;
			neg_q_r <= dvd_neg ^ (d.signed_op & d.divisor[15]);
			neg_r_r <= dvd_neg;
		end else if (state_r == dsp_datapath_pkg::DIV_RUN && d.step) begin
			// sixteen quotient bits; the remaining steps only fill out the fixed cycle count
			if (cnt_r < 5'(dsp_datapath_pkg::WORD_W)) begin
				if (!trial[32]) begin
					rem_r <= trial;
					quo_r <= {quo_r[30:0], 1'b1};
				end else begin
					rem_r <= {rem_r[31:0], quo_r[31]};
					quo_r <= {quo_r[30:0], 1'b0};
				end
			end
			cnt_r <= cnt_r + 5'h01;
			if (cnt_r == 5'(N_STEPS - 1))
				state_r <= dsp_datapath_pkg::DIV_DONE;
		end
	end

	always_comb begin
		// magnitudes take their signs back here; results that overflow 16 bits are undefined
		d.busy = (state_r == dsp_datapath_pkg::DIV_RUN);
		d.done = (state_r == dsp_datapath_pkg::DIV_DONE);
		d.quotient = neg_q_r ? 16'h0 - quo_r[15:0] : quo_r[15:0];
		d.remainder = neg_r_r ? 16'h0 - rem_r[15:0] : rem_r[15:0];
	end
endmodule

/* File: hw/div_step_if.sv */
/*
 * carrier between datapath top and the divider step engine.
 * assumes both ends on ref_clk_in.
 */
`timescale 1ns/1ps
interface div_step_if;
	logic start;
	logic step;
	logic wide;
	logic signed_op;
	logic frac;
	logic [31:0] dividend;
	logic [15:0] divisor;
	logic busy;
	logic done;
	logic [15:0] quotient;
	logic [15:0] remainder;
	modport ctrl (output start, output step, output wide, output signed_op, output frac,
		output dividend, output divisor, input busy, input done, input quotient,
		input remainder);
	modport engine (input start, input step, input wide, input signed_op, input frac,
		input dividend, input divisor, output busy, output done, output quotient,
		output remainder);
endinterface

/* File: hw/dsp_datapath_pkg.sv */
/*
 * constants and types for the arithmetic datapath: multiplier, divider,
 * barrel shifter and data space write saturation.
 * assumes one core clock; one instruction cycle per clock edge.
 */
// Overview of operation
// - one 17x17 multiplier gives a product in a single cycle, shared by integer and DSP ops.
// - the 17th operand bit carries the sign so signed, unsigned and mixed 16x16 products work.
// - the divider does 16/16 and 32/16 division in fractional and integer forms.
// - division is iterative, one step per repeated instruction, 19 cycles in total.
// - an interrupt between steps leaves the partial divide state intact so it resumes.
// - the shifter does an arithmetic or logical right shift, or a left shift, up to 16 bits.
// - the shifter operand comes from accumulator A, accumulator B or the X bus.
// - a positive shift amount shifts right, a negative one shifts left, zero passes through.
// - the shifter is 40 bits wide, giving a 40-bit DSP result and a 16-bit integer result.
// - X bus data sits at bits 16 to 31 for right shifts and bits 0 to 15 for left shifts.
// - integer and DSP instruction classes can both use the shifter.
// - write saturation takes the rounded 1.15 word, accumulator overflow and round overflow.
// - saturation changes only the stored word, never the source accumulator.
// - with saturation on, a value above 0x007fff is stored as 0x7fff.
// - with saturation on, a value below 0xff8000 is stored as 0x8000.
// - bit 39 of the source accumulator gives the sign used to choose the limit.
// - with saturation off, the rounded word is stored unmodified.
package dsp_datapath_pkg;
	localparam int ACC_W = 40;
	localparam int WORD_W = 16;
	localparam int MUL_W = 17;
	localparam int SHIFT_MAX = 16;
	localparam int XBUS_RIGHT_LSB = 16;
	localparam int XBUS_LEFT_LSB = 0;
	localparam int ACC_SIGN_BIT = 39;
	localparam int DIV_CYCLES = 19;
	localparam int DIV_STEPS = 18;
	localparam logic [15:0] SAT_POS = 16'h7fff;
	localparam logic [15:0] SAT_NEG = 16'h8000;

	typedef enum logic [1:0] {
		SRC_ACC_A,
		SRC_ACC_B,
		SRC_XBUS
	} shift_src_t;

	typedef enum {
		DIV_IDLE,
		DIV_RUN,
		DIV_DONE
	} div_state_t;
endpackage

/* File: hw/dsp_shift_saturate_datapath.sv */
/*
 * arithmetic datapath: single-cycle 17x17 multiplier, iterative divider,
 * 40-bit barrel shifter and data space write saturation.
 * assumes the decoder drives operands synchronous to ref_clk_in, one op per cycle.
 */
`timescale 1ns/1ps
module dsp_shift_saturate_datapath (
	input wire logic ref_clk_in,
	input wire logic nrst_in,
	input wire logic mul_valid_in,
	input wire logic [15:0] mul_a_in,
	input wire logic [15:0] mul_b_in,
	input wire logic mul_a_signed_in,
	input wire logic mul_b_signed_in,
	output logic [33:0] mul_prod_out,
	output logic mul_valid_out,
	input wire logic div_start_in,
	input wire logic div_step_in,
	input wire logic div_wide_in,
	input wire logic div_signed_in,
	input wire logic div_frac_in,
	input wire logic [31:0] div_dividend_in,
	input wire logic [15:0] div_divisor_in,
	output logic div_busy_out,
	output logic div_done_out,
	output logic [15:0] div_quotient_out,
	output logic [15:0] div_remainder_out,
	input wire logic shift_valid_in,
	input wire logic [1:0] shift_src_in,
	input wire logic shift_arith_in,
	input wire logic shift_dsp_in,
	input wire logic signed [5:0] shift_amt_in,
	input wire logic [39:0] acc_a_in,
	input wire logic [39:0] acc_b_in,
	input wire logic [15:0] xbus_in,
	output logic [39:0] shift_acc_out,
	output logic [15:0] shift_word_out,
	output logic shift_valid_out,
	input wire logic data_write_saturate_enable_in,
	input wire logic wr_valid_in,
	input wire logic [15:0] wr_round_in,
	input wire logic wr_acc_ovf_in,
	input wire logic wr_round_ovf_in,
	input wire logic wr_acc_sign_in,
	output logic [15:0] wr_data_out,
	output logic wr_valid_out
);
	localparam int AW = dsp_datapath_pkg::ACC_W;
	localparam int MW = dsp_datapath_pkg::MUL_W;
	localparam int SMAX = dsp_datapath_pkg::SHIFT_MAX;

	initial begin
		if (AW != 40 || MW != 17 || SMAX != 16)
			$error("datapath widths not supported");
	end

	// multiplier: operands extended to 17 bits, sign bit from each mode flag
	logic signed [MW-1:0] mul_a_ext;
	logic signed [MW-1:0] mul_b_ext;
	logic signed [2*MW-1:0] mul_full;

	always_comb begin
		mul_a_ext = $signed({mul_a_signed_in & mul_a_in[15], mul_a_in});
		mul_b_ext = $signed({mul_b_signed_in & mul_b_in[15], mul_b_in});
		mul_full = mul_a_ext * mul_b_ext;
	end

	always_ff @(posedge ref_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			mul_prod_out <= 34'h0;
			mul_valid_out <= 1'b0;
		end else begin
			mul_valid_out <= mul_valid_in;
			if (mul_valid_in)
				mul_prod_out <= mul_full;
		end
	end

	// divider: step engine holds all partial state
	div_step_if div_bus ();

	always_comb begin
		div_bus.start = div_start_in;
		div_bus.step = div_step_in;
		div_bus.wide = div_wide_in;
		div_bus.signed_op = div_signed_in;
		div_bus.frac = div_frac_in;
		div_bus.dividend = div_dividend_in;
		div_bus.divisor = div_divisor_in;
		div_busy_out = div_bus.busy;
		div_done_out = div_bus.done;
	end

	div_step_engine u_div (
		.ref_clk_in(ref_clk_in),
		.nrst_in(nrst_in),
		.d(div_bus)
	);

	always_ff @(posedge ref_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			div_quotient_out <= 16'h0000;
			div_remainder_out <= 16'h0000;
		end else begin
			div_quotient_out <= div_bus.quotient;
			div_remainder_out <= div_bus.remainder;
		end
	end

	// barrel shifter
	logic [AW-1:0] sh_opnd;
	logic [AW-1:0] sh_res;
	logic [4:0] sh_mag;
	logic sh_left;
	logic sh_fill;

	always_comb begin
		sh_left = shift_amt_in[5];
		sh_mag = sh_left ? 5'(-shift_amt_in) : shift_amt_in[4:0];
		// the most negative amount has no 5-bit magnitude
		if (sh_left && shift_amt_in[4:0] == 5'h00)
			sh_mag = 5'(SMAX);
		if (sh_mag > 5'(SMAX))
			sh_mag = 5'(SMAX);
		unique case (shift_src_in)
			2'(dsp_datapath_pkg::SRC_ACC_A): sh_opnd = acc_a_in;
			2'(dsp_datapath_pkg::SRC_ACC_B): sh_opnd = acc_b_in;
			default: begin
				// xbus word placed per direction
				sh_opnd = 40'h0;
				if (sh_left)
					sh_opnd[dsp_datapath_pkg::XBUS_LEFT_LSB +: 16] = xbus_in;
				else
					sh_opnd[dsp_datapath_pkg::XBUS_RIGHT_LSB +: 16] = xbus_in;
			end
		endcase
		sh_fill = shift_arith_in & sh_opnd[AW-1];
		if (shift_src_in == 2'(dsp_datapath_pkg::SRC_XBUS))
			sh_fill = shift_arith_in & xbus_in[15];
		if (shift_src_in == 2'(dsp_datapath_pkg::SRC_XBUS) && !sh_left && sh_fill)
			sh_opnd[AW-1:32] = 8'hff;
		if (sh_left)
			sh_res = sh_opnd << sh_mag;
		else if (sh_fill)
			sh_res = ~(~sh_opnd >> sh_mag);
		else
			sh_res = sh_opnd >> sh_mag;
	end

	always_ff @(posedge ref_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			shift_acc_out <= 40'h0;
			shift_word_out <= 16'h0000;
			shift_valid_out <= 1'b0;
		end else begin
			shift_valid_out <= shift_valid_in;
			if (shift_valid_in && shift_dsp_in)
				shift_acc_out <= sh_res;
			if (shift_valid_in && !shift_dsp_in) begin
				if (shift_src_in == 2'(dsp_datapath_pkg::SRC_XBUS) && !sh_left)
					shift_word_out <= sh_res[31:16];
				else
					shift_word_out <= sh_res[15:0];
			end
		end
	end

	// write saturation: output is a separate word, accumulator inputs are only read
	logic [15:0] sat_word;
	logic sat_ovf;

	always_comb begin
		sat_ovf = wr_acc_ovf_in | wr_round_ovf_in;
		sat_word = wr_round_in;
		if (data_write_saturate_enable_in && sat_ovf) begin
			if (wr_acc_sign_in)
				sat_word = dsp_datapath_pkg::SAT_NEG;
			else
				sat_word = dsp_datapath_pkg::SAT_POS;
		end
	end

	always_ff @(posedge ref_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			wr_data_out <= 16'h0000;
			wr_valid_out <= 1'b0;
		end else begin
			wr_valid_out <= wr_valid_in;
			if (wr_valid_in)
				wr_data_out <= sat_word;
		end
	end

	property p_mul_one_cycle;
		@(posedge ref_clk_in) disable iff (!nrst_in)
		mul_valid_in |=> mul_valid_out && mul_prod_out == $past(mul_full);
	endproperty
	a_mul_one_cycle: assert property (p_mul_one_cycle) else $error("product late");

	property p_mul_unsigned;
		@(posedge ref_clk_in) disable iff (!nrst_in)
		mul_valid_in && !mul_a_signed_in && !mul_b_signed_in |=> !mul_prod_out[33];
	endproperty
	a_mul_unsigned: assert property (p_mul_unsigned) else $error("unsigned product negative");

	sequence s_div_start;
		div_start_in;
	endsequence
	sequence s_div_run;
		div_busy_out [*8];
	endsequence
	property p_div_runs;
		@(posedge ref_clk_in) disable iff (!nrst_in)
		s_div_start ##1 !div_start_in [*8] |-> s_div_run;
	endproperty
	a_div_runs: assert property (p_div_runs) else $error("divide ended early");

	property p_div_hold;
		@(posedge ref_clk_in) disable iff (!nrst_in)
		div_busy_out && !div_step_in && !div_start_in |=> div_busy_out;
	endproperty
	a_div_hold: assert property (p_div_hold) else $error("divide lost while stalled");

	property p_shift_zero;
		@(posedge ref_clk_in) disable iff (!nrst_in)
		shift_valid_in && shift_dsp_in && shift_amt_in == 6'sd0
			&& shift_src_in == 2'(dsp_datapath_pkg::SRC_ACC_A) |=> shift_acc_out == $past(acc_a_in);
	endproperty
	a_shift_zero: assert property (p_shift_zero) else $error("zero shift changed data");

	property p_sat_pos;
		@(posedge ref_clk_in) disable iff (!nrst_in)
		wr_valid_in && data_write_saturate_enable_in && wr_acc_ovf_in && !wr_acc_sign_in
			|=> wr_data_out == 16'h7fff;
	endproperty
	a_sat_pos: assert property (p_sat_pos) else $error("positive clamp wrong");

	property p_sat_neg;
		@(posedge ref_clk_in) disable iff (!nrst_in)
		wr_valid_in && data_write_saturate_enable_in && wr_round_ovf_in && wr_acc_sign_in
			|=> wr_data_out == 16'h8000;
	endproperty
	a_sat_neg: assert property (p_sat_neg) else $error("negative clamp wrong");

	property p_sat_off;
		@(posedge ref_clk_in) disable iff (!nrst_in)
		wr_valid_in && !data_write_saturate_enable_in |=> wr_data_out == $past(wr_round_in);
	endproperty
	a_sat_off: assert property (p_sat_off) else $error("unsaturated word modified");

	property p_sat_sign;
		@(posedge ref_clk_in) disable iff (!nrst_in)
		wr_valid_in && data_write_saturate_enable_in && (wr_acc_ovf_in || wr_round_ovf_in)
			|=> wr_data_out[15] == $past(wr_acc_sign_in);
	endproperty
	a_sat_sign: assert property (p_sat_sign) else $error("clamp sign wrong");

	// widest shifts: any amount past sixteen places acts as sixteen
	property p_shift_left_max;
		@(posedge ref_clk_in) disable iff (!nrst_in)
		shift_valid_in && shift_dsp_in && shift_amt_in <= -6'sh10
			&& shift_src_in == 2'(dsp_datapath_pkg::SRC_ACC_A)
			|=> shift_acc_out == {$past(acc_a_in[23:0]), 16'h0000};
	endproperty
	a_shift_left_max: assert property (p_shift_left_max) else $error("left limit wrong");

	property p_shift_right_max;
		@(posedge ref_clk_in) disable iff (!nrst_in)
		shift_valid_in && shift_dsp_in && !shift_arith_in && shift_amt_in >= 6'sh10
			&& shift_src_in == 2'(dsp_datapath_pkg::SRC_ACC_B)
			|=> shift_acc_out == {16'h0000, $past(acc_b_in[39:16])};
	endproperty
	a_shift_right_max: assert property (p_shift_right_max) else $error("right limit wrong");

	property p_xbus_word;
		@(posedge ref_clk_in) disable iff (!nrst_in)
		shift_valid_in && !shift_dsp_in && shift_amt_in == 6'sh00
			&& shift_src_in == 2'(dsp_datapath_pkg::SRC_XBUS) |=> shift_word_out == $past(xbus_in);
	endproperty
	a_xbus_word: assert property (p_xbus_word) else $error("x bus word misplaced");

	property p_word_hold;
		@(posedge ref_clk_in) disable iff (!nrst_in)
		shift_valid_in && shift_dsp_in |=> $stable(shift_word_out);
	endproperty
	a_word_hold: assert property (p_word_hold) else $error("dsp shift hit word");

	property p_int_class;
		@(posedge ref_clk_in) disable iff (!nrst_in)
		shift_valid_in && !shift_dsp_in |=> shift_valid_out && $stable(shift_acc_out);
	endproperty
	a_int_class: assert property (p_int_class) else $error("integer shift hit acc");

	// a finished divide ignores stray steps until the next start
	sequence s_div_idle_step;
		div_done_out && !div_start_in;
	endsequence
	property p_div_done_hold;
		@(posedge ref_clk_in) disable iff (!nrst_in)
		s_div_idle_step |=> div_done_out && !div_busy_out;
	endproperty
	a_div_done_hold: assert property (p_div_done_hold) else $error("done lost");

	property p_div_load;
		@(posedge ref_clk_in) disable iff (!nrst_in)
		div_start_in |=> div_busy_out && !div_done_out;
	endproperty
	a_div_load: assert property (p_div_load) else $error("divide did not start");
endmodule
